// ==== verilog/i2cm_regs.vh ====
`ifndef I2CM_REGS_VH
`define I2CM_REGS_VH
`define I2CM_GCALL_ADDR      8'h00
`define I2CM_RW_WRITE        1'b0
`define I2CM_RW_READ         1'b1
`define I2CM_CON2_GENERAL_CALL_ENABLE_BIT   7
`define I2CM_CON2_ACKST_BIT  6
`define I2CM_CON2_STOP_BIT   2
`define I2CM_CON2_START_BIT  0
`define I2CM_MODE_MASTER     4'h8
`define I2CM_MODE_SLV7       4'h6
`define I2CM_MODE_SLV10      4'h7
`define I2CM_RELOAD_RST      7'h00
`define I2CM_PHASES_PER_CYC  4
`define I2CM_BITS_PER_BYTE   4'h8
`endif

// ==== verilog/i2cm_port.v ====
`timescale 1ns/100ps
`include "i2cm_regs.vh"
module i2cm_port #(
   parameter RELOAD_W = 7
) (
   input  wire       CLOCK_IN,
   input  wire       RESET_IN,
   input  wire       PORT_ENABLE_BIT_IN,
   input  wire [3:0] PORT_MODE_SELECT_IN,
   input  wire       GENERAL_CALL_ENABLE_IN,
   input  wire       TEN_BIT_MODE_IN,
   input  wire [7:0] ADDRESS_RATE_REG_IN,
   input  wire       ADDRESS_RATE_WR_IN,
   input  wire       START_REQUEST_IN,
   input  wire       STOP_REQUEST_IN,
   input  wire       RECEIVE_ENABLE_IN,
   input  wire       ACK_DATA_IN,
   input  wire [7:0] BUFFER_WDATA_IN,
   input  wire       BUFFER_WR_IN,
   input  wire       BUFFER_RD_IN,
   input  wire       IRQ_CLEAR_IN,
   input  wire       COLLISION_CLEAR_IN,
   input  wire       SCL_IN,
   input  wire       SDA_IN,
   output reg        SCL_OUT,
   output reg        SCL_OE_OUT,
   output reg        SDA_OUT,
   output reg        SDA_OE_OUT,
   output reg  [7:0] TRANSFER_BUFFER_OUT,
   output reg        BUFFER_FULL_FLAG_OUT,
   output reg        PORT_IRQ_FLAG_OUT,
   output reg        ADDRESS_UPDATE_NEEDED_OUT,
   output reg        WRITE_COLLISION_FLAG_OUT,
   output reg        ACK_RECEIVED_STATUS_OUT,
   output reg        START_SEEN_OUT,
   output reg        STOP_SEEN_OUT,
   output reg        BUSY_OUT
);
   localparam ST_IDLE  = 3'd0;
   localparam ST_START = 3'd1;
   localparam ST_BITLO = 3'd2;
   localparam ST_BITHI = 3'd3;
   localparam ST_STOP  = 3'd4;
   localparam ST_ACKLO = 3'd5;
   localparam ST_ACKHI = 3'd6;

   reg [2:0]          state_reg;
   reg [1:0]          phase_reg;
   reg [RELOAD_W-1:0] div_reg;
   reg                div_run_reg;
   reg [3:0]          bit_reg;
   reg [7:0]          shift_register;
   reg                rx_reg;
   reg                acking_reg;
   reg [1:0]          sub_reg;
   reg                scl_d_reg;
   reg                sda_d_reg;
   reg [3:0]          sbit_reg;
   reg                s_active_reg;
   reg                s_ten_hi_reg;

   wire master  = PORT_ENABLE_BIT_IN &&
                  PORT_MODE_SELECT_IN == `I2CM_MODE_MASTER;
   wire slave   = PORT_ENABLE_BIT_IN && !master;
   wire [RELOAD_W-1:0] reload = ADDRESS_RATE_REG_IN[RELOAD_W-1:0];
   // two decrements per four-phase instruction cycle
   wire dec_tick = phase_reg[0];
   wire rollover = div_run_reg && dec_tick && div_reg == {RELOAD_W{1'b0}};
   wire scl_rise = SCL_IN && !scl_d_reg;
   wire scl_fall = !SCL_IN && scl_d_reg;
   wire bus_start = SCL_IN && scl_d_reg && sda_d_reg && !SDA_IN;
   wire bus_stop  = SCL_IN && scl_d_reg && !sda_d_reg && SDA_IN;
   wire bus_free  = STOP_SEEN_OUT || (!START_SEEN_OUT && !STOP_SEEN_OUT);

   function is_gcall;
      input [7:0] b;
      input       en;
      begin
         is_gcall = en && b == `I2CM_GCALL_ADDR;
      end
   endfunction

   always @(posedge CLOCK_IN) begin
      if (RESET_IN) begin
         phase_reg <= 2'b00;
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         phase_reg <= phase_reg + 2'b01;
         scl_d_reg <= SCL_IN;
         sda_d_reg <= SDA_IN;
      end
   end

   // start and stop detection
   always @(posedge CLOCK_IN) begin
      if (RESET_IN || !PORT_ENABLE_BIT_IN) begin
         START_SEEN_OUT <= 1'b0;
         STOP_SEEN_OUT  <= 1'b0;
      end else if (bus_start) begin
         START_SEEN_OUT <= 1'b1;
         STOP_SEEN_OUT  <= 1'b0;
      end else if (bus_stop) begin
         START_SEEN_OUT <= 1'b0;
         STOP_SEEN_OUT  <= 1'b1;
      end
   end

   always @(posedge CLOCK_IN) begin
      if (RESET_IN || !PORT_ENABLE_BIT_IN) begin
         state_reg <= ST_IDLE;
         div_reg <= `I2CM_RELOAD_RST;
         div_run_reg <= 1'b0;
         bit_reg <= 4'h0;
         shift_register <= 8'h00;
         rx_reg <= 1'b0;
         acking_reg <= 1'b0;
         sub_reg <= 2'b00;
         sbit_reg <= 4'h0;
         s_active_reg <= 1'b0;
         s_ten_hi_reg <= 1'b0;
         SCL_OUT <= 1'b0;
         SCL_OE_OUT <= 1'b0;
         SDA_OUT <= 1'b0;
         SDA_OE_OUT <= 1'b0;
         TRANSFER_BUFFER_OUT <= 8'h00;
         BUFFER_FULL_FLAG_OUT <= 1'b0;
         PORT_IRQ_FLAG_OUT <= 1'b0;
         ADDRESS_UPDATE_NEEDED_OUT <= 1'b0;
         WRITE_COLLISION_FLAG_OUT <= 1'b0;
         ACK_RECEIVED_STATUS_OUT <= 1'b0;
         BUSY_OUT <= 1'b0;
      end else begin
         // hardware sets win over software clears
         if (IRQ_CLEAR_IN)
            PORT_IRQ_FLAG_OUT <= 1'b0;
         if (COLLISION_CLEAR_IN)
            WRITE_COLLISION_FLAG_OUT <= 1'b0;
         if (BUFFER_RD_IN && !master)
            BUFFER_FULL_FLAG_OUT <= 1'b0;
         if (ADDRESS_RATE_WR_IN)
            ADDRESS_UPDATE_NEEDED_OUT <= 1'b0;
         BUSY_OUT <= state_reg != ST_IDLE;

         // divider counts down to zero, reloads while an operation runs
         if (div_run_reg && dec_tick) begin
            if (div_reg == {RELOAD_W{1'b0}})
               div_reg <= reload;
            else
               div_reg <= div_reg - {{(RELOAD_W-1){1'b0}}, 1'b1};
         end

         if (master) begin
            case (state_reg)
            ST_IDLE: begin
               div_run_reg <= 1'b0;
               if (BUFFER_WR_IN) begin
                  TRANSFER_BUFFER_OUT <= BUFFER_WDATA_IN;
                  shift_register <= BUFFER_WDATA_IN;
                  BUFFER_FULL_FLAG_OUT <= 1'b1;
                  rx_reg <= 1'b0;
                  bit_reg <= 4'h0;
                  div_reg <= reload;
                  div_run_reg <= 1'b1;
                  SCL_OE_OUT <= 1'b1;
                  state_reg <= ST_BITLO;
               end else if (START_REQUEST_IN && bus_free) begin
                  div_reg <= reload;
                  div_run_reg <= 1'b1;
                  sub_reg <= 2'b00;
                  state_reg <= ST_START;
               end else if (STOP_REQUEST_IN) begin
                  div_reg <= reload;
                  div_run_reg <= 1'b1;
                  sub_reg <= 2'b00;
                  SDA_OE_OUT <= 1'b1;
                  state_reg <= ST_STOP;
               end else if (RECEIVE_ENABLE_IN) begin
                  rx_reg <= 1'b1;
                  bit_reg <= 4'h0;
                  div_reg <= reload;
                  div_run_reg <= 1'b1;
                  SDA_OE_OUT <= 1'b0;
                  SCL_OE_OUT <= 1'b1;
                  state_reg <= ST_BITLO;
               end
            end
            ST_START: if (rollover) begin
               sub_reg <= sub_reg + 2'b01;
               if (sub_reg == 2'b00) begin
                  SDA_OE_OUT <= 1'b1;
               end else begin
                  SCL_OE_OUT <= 1'b1;
                  PORT_IRQ_FLAG_OUT <= 1'b1;
                  state_reg <= ST_IDLE;
               end
            end
            ST_BITLO: begin
               // data moves one clock after scl falls, never on an scl edge,
               // so no receiver sees a false start or stop; a reload of zero
               // can still put both on one edge
               if (!rx_reg && bit_reg < `I2CM_BITS_PER_BYTE)
                  SDA_OE_OUT <= !shift_register[7];
               else if (rx_reg && acking_reg)
                  SDA_OE_OUT <= !ACK_DATA_IN;
               else
                  SDA_OE_OUT <= 1'b0;
               if (rollover) begin
                  SCL_OE_OUT <= 1'b0;
                  state_reg <= ST_BITHI;
               end
            end
            ST_BITHI: if (rollover) begin
               SCL_OE_OUT <= 1'b1;
               if (bit_reg == `I2CM_BITS_PER_BYTE) begin
                  if (!rx_reg)
                     ACK_RECEIVED_STATUS_OUT <= SDA_IN;
                  acking_reg <= 1'b0;
                  PORT_IRQ_FLAG_OUT <= 1'b1;
                  state_reg <= ST_IDLE;
               end else begin
                  if (rx_reg)
                     shift_register <= {shift_register[6:0], SDA_IN};
                  else
                     shift_register <= {shift_register[6:0], 1'b0};
                  bit_reg <= bit_reg + 4'h1;
                  if (bit_reg == 4'h7) begin
                     if (rx_reg) begin
                        TRANSFER_BUFFER_OUT <= {shift_register[6:0], SDA_IN};
                        BUFFER_FULL_FLAG_OUT <= 1'b1;
                        acking_reg <= 1'b1;
                     end else
                        BUFFER_FULL_FLAG_OUT <= 1'b0;
                  end
                  state_reg <= ST_BITLO;
               end
            end
            ST_STOP: if (rollover) begin
               sub_reg <= sub_reg + 2'b01;
               if (sub_reg == 2'b00)
                  SCL_OE_OUT <= 1'b0;
               else begin
                  SDA_OE_OUT <= 1'b0;
                  PORT_IRQ_FLAG_OUT <= 1'b1;
                  state_reg <= ST_IDLE;
               end
            end
            default: state_reg <= ST_IDLE;
            endcase
            // no queueing: a write while busy is dropped
            if (BUFFER_WR_IN && state_reg != ST_IDLE)
               WRITE_COLLISION_FLAG_OUT <= 1'b1;
         end else if (slave) begin
            SCL_OE_OUT <= 1'b0;
            if (bus_start) begin
               sbit_reg <= 4'h0;
               s_active_reg <= 1'b1;
            end else if (bus_stop)
               s_active_reg <= 1'b0;
            else if (s_active_reg && scl_rise
                     && sbit_reg < `I2CM_BITS_PER_BYTE) begin
               shift_register <= {shift_register[6:0], SDA_IN};
               sbit_reg <= sbit_reg + 4'h1;
               if (sbit_reg == 4'h7) begin
                  if (is_gcall({shift_register[6:0], SDA_IN},
                               GENERAL_CALL_ENABLE_IN)) begin
                     TRANSFER_BUFFER_OUT <= {shift_register[6:0], SDA_IN};
                     BUFFER_FULL_FLAG_OUT <= 1'b1;
                     s_ten_hi_reg <= 1'b0;
                  end else if ({shift_register[6:0], SDA_IN} ==
                               ADDRESS_RATE_REG_IN) begin
                     TRANSFER_BUFFER_OUT <= {shift_register[6:0], SDA_IN};
                     BUFFER_FULL_FLAG_OUT <= 1'b1;
                     s_ten_hi_reg <= TEN_BIT_MODE_IN;
                  end else
                     s_active_reg <= 1'b0;
               end
            end else if (s_active_reg && scl_fall
                         && sbit_reg == `I2CM_BITS_PER_BYTE) begin
               SDA_OE_OUT <= 1'b1;
               sbit_reg <= sbit_reg + 4'h1;
            end else if (s_active_reg && scl_fall
                         && sbit_reg == 4'h9) begin
               SDA_OE_OUT <= 1'b0;
               sbit_reg <= 4'h0;
               PORT_IRQ_FLAG_OUT <= 1'b1;
               if (s_ten_hi_reg)
                  ADDRESS_UPDATE_NEEDED_OUT <= 1'b1;
               s_ten_hi_reg <= 1'b0;
            end
         end
      end
   end
endmodule

// ==== testbench/i2cm_asserts.sv ====
`timescale 1ns/100ps
`include "i2cm_regs.vh"
module i2cm_asserts (
   input wire       CLOCK_IN,
   input wire       RESET_IN,
   input wire       PORT_ENABLE_BIT_IN,
   input wire [3:0] PORT_MODE_SELECT_IN,
   input wire [7:0] ADDRESS_RATE_REG_IN,
   input wire       BUFFER_WR_IN,
   input wire       IRQ_CLEAR_IN,
   input wire       SCL_OUT,
   input wire       SCL_OE_OUT,
   input wire       SDA_OUT,
   input wire       SDA_OE_OUT,
   input wire [7:0] TRANSFER_BUFFER_OUT,
   input wire       BUFFER_FULL_FLAG_OUT,
   input wire       PORT_IRQ_FLAG_OUT,
   input wire       ADDRESS_UPDATE_NEEDED_OUT,
   input wire       WRITE_COLLISION_FLAG_OUT,
   input wire       START_SEEN_OUT,
   input wire       STOP_SEEN_OUT,
   input wire       BUSY_OUT
);
   wire       mst = PORT_MODE_SELECT_IN == `I2CM_MODE_MASTER &&
                    PORT_ENABLE_BIT_IN;
   wire [8:0] rb = {1'b0, ADDRESS_RATE_REG_IN[6:0], 1'b0} + 9'h002;
   reg  [8:0] hi_cnt;
   reg        hi_ok;
   // high time is only measured from a release inside an operation
   always @(posedge CLOCK_IN) begin
      if (RESET_IN || !BUSY_OUT) begin
         hi_cnt <= 9'h000;
         hi_ok  <= 1'b0;
      end else if ($fell(SCL_OE_OUT)) begin
         hi_cnt <= 9'h001;
         hi_ok  <= 1'b1;
      end else begin
         hi_cnt <= hi_cnt + 9'h001;
      end
   end
   default clocking @(posedge CLOCK_IN); endclocking
   default disable iff (RESET_IN);
   sequence wr_busy;
      BUFFER_WR_IN && BUSY_OUT && $past(BUSY_OUT) && mst &&
      !PORT_IRQ_FLAG_OUT;
   endsequence
   reset_clear_a: assert property (disable iff (1'b0)
      $fell(RESET_IN) |-> !(PORT_IRQ_FLAG_OUT | BUFFER_FULL_FLAG_OUT |
      START_SEEN_OUT | STOP_SEEN_OUT | WRITE_COLLISION_FLAG_OUT |
      ADDRESS_UPDATE_NEEDED_OUT)) else $error("flags set after reset");
   disable_clear_a: assert property (!PORT_ENABLE_BIT_IN |=>
      !START_SEEN_OUT && !STOP_SEEN_OUT) else $error("seen bits kept");
   collision_set_a: assert property (wr_busy |=>
      WRITE_COLLISION_FLAG_OUT) else $error("collision not flagged");
   collision_drop_a: assert property (wr_busy |=>
      $stable(TRANSFER_BUFFER_OUT)) else $error("refused write landed");
   open_drain_a: assert property (!SCL_OUT && !SDA_OUT &&
      ($past(PORT_ENABLE_BIT_IN) || !(SCL_OE_OUT || SDA_OE_OUT)))
      else $error("bus line driven high or while disabled");
   pin_hold_a: assert property (!BUSY_OUT && $past(!BUSY_OUT) && mst &&
      $past(mst) |-> $stable(SCL_OE_OUT)) else $error("clock pin moved");
   scl_high_a: assert property ($rose(SCL_OE_OUT) && hi_ok && mst |->
      hi_cnt + 9'h001 >= rb && hi_cnt <= rb + 9'h004)
      else $error("clock high time off");
   irq_done_a: assert property ($fell(BUSY_OUT) && mst && $past(mst)
      |-> PORT_IRQ_FLAG_OUT) else $error("no irq at end of operation");
   irq_keep_a: assert property (PORT_IRQ_FLAG_OUT && !IRQ_CLEAR_IN ##1
      PORT_ENABLE_BIT_IN |-> PORT_IRQ_FLAG_OUT) else $error("irq lost");
   cover property ($rose(WRITE_COLLISION_FLAG_OUT));
   cover property ($rose(ADDRESS_UPDATE_NEEDED_OUT));
   cover property ($rose(STOP_SEEN_OUT));
endmodule
bind i2cm_port i2cm_asserts chk (.CLOCK_IN, .RESET_IN, .PORT_ENABLE_BIT_IN,
   .PORT_MODE_SELECT_IN, .ADDRESS_RATE_REG_IN, .BUFFER_WR_IN, .IRQ_CLEAR_IN,
   .SCL_OUT, .SCL_OE_OUT, .SDA_OUT, .SDA_OE_OUT, .TRANSFER_BUFFER_OUT,
   .BUFFER_FULL_FLAG_OUT, .PORT_IRQ_FLAG_OUT, .ADDRESS_UPDATE_NEEDED_OUT,
   .WRITE_COLLISION_FLAG_OUT, .START_SEEN_OUT, .STOP_SEEN_OUT, .BUSY_OUT);

// ==== testbench/i2cm_bus_model.sv ====
`timescale 1ns/100ps
module i2cm_bus_model (
   input  wire clk_in,
   input  wire scl_in,
   input  wire sda_in,
   output reg  scl_lo_out,
   output reg  sda_lo_out
);
   reg       ack_en;
   reg       bb;
   reg [7:0] rx_byte;
   reg       tx_en;
   reg       ack_seen;
   reg [7:0] tx_byte;
   integer   cnt;
   initial begin
      {scl_lo_out, sda_lo_out, bb, rx_byte, tx_en, ack_seen, tx_byte} = 0;
      ack_en = 1;
      cnt = 9;
   end
   // the fall of scl that ends a start is not a bit, hence -1
   always @(negedge sda_in) if (scl_in) cnt = -1;
   always @(posedge scl_in) begin
      if (cnt >= 0 && cnt < 8)
         rx_byte = {rx_byte[6:0], sda_in};
      if (cnt == 8)
         ack_seen = sda_in;
   end
   // as a sender the model leaves the ninth slot to the master
   always @(negedge scl_in) begin
      cnt = cnt + 1;
      if (cnt == 9) cnt = 0;
      #5 if (!bb) sda_lo_out = (cnt == 8) ? ack_en && !tx_en
                                 : tx_en && cnt < 8 && !tx_byte[7 - cnt];
   end
   task wt;
      repeat (10) @(negedge clk_in);
   endtask
   // acts as a foreign master: start, one byte, ninth slot, stop
   task frame(input [7:0] b);
      integer i;
      begin
         bb = 1;
         sda_lo_out = 1;
         wt;
         scl_lo_out = 1;
         for (i = 7; i >= 0; i--) begin
            sda_lo_out = !b[i];
            wt;
            scl_lo_out = 0;
            wt;
            scl_lo_out = 1;
         end
         sda_lo_out = 0;
         wt;
         scl_lo_out = 0;
         wt;
         scl_lo_out = 1;
         sda_lo_out = 1;
         wt;
         scl_lo_out = 0;
         wt;
         sda_lo_out = 0;
         wt;
         bb = 0;
      end
   endtask
endmodule

// ==== testbench/i2cm_port_tb.sv ====
`timescale 1ns/100ps
`include "i2cm_regs.vh"
module i2cm_port_tb;
   reg        clk, rst, en, general_call_enable, ten, ack_d;
   reg  [3:0] mode;
   reg  [7:0] ar, wd, pl;
   reg [10:0] t;
   integer    err_count, n_compared, i;
   wire       scl_oe, sda_oe, m_scl, m_sda, irq, write_collision_flag, ackst;
   wire       sseen, pseen, bf, ua, busy;
   wire [7:0] tbuf;
   wire       scl = !(scl_oe | m_scl);
   wire       sda = !(sda_oe | m_sda);
   i2cm_port dut (.CLOCK_IN(clk), .RESET_IN(rst), .PORT_ENABLE_BIT_IN(en),
      .PORT_MODE_SELECT_IN(mode), .GENERAL_CALL_ENABLE_IN(general_call_enable),
      .TEN_BIT_MODE_IN(ten), .ADDRESS_RATE_REG_IN(ar),
      .ADDRESS_RATE_WR_IN(pl[6]), .START_REQUEST_IN(pl[0]),
      .STOP_REQUEST_IN(pl[1]), .RECEIVE_ENABLE_IN(pl[2]),
      .ACK_DATA_IN(ack_d), .BUFFER_WDATA_IN(wd), .BUFFER_WR_IN(pl[3]),
      .BUFFER_RD_IN(pl[7]), .IRQ_CLEAR_IN(pl[4]),
      .COLLISION_CLEAR_IN(pl[5]), .SCL_IN(scl), .SDA_IN(sda), .SCL_OUT(),
      .SCL_OE_OUT(scl_oe), .SDA_OUT(), .SDA_OE_OUT(sda_oe),
      .TRANSFER_BUFFER_OUT(tbuf), .BUFFER_FULL_FLAG_OUT(bf),
      .PORT_IRQ_FLAG_OUT(irq), .ADDRESS_UPDATE_NEEDED_OUT(ua),
      .WRITE_COLLISION_FLAG_OUT(write_collision_flag), .ACK_RECEIVED_STATUS_OUT(ackst),
      .START_SEEN_OUT(sseen), .STOP_SEEN_OUT(pseen), .BUSY_OUT(busy));
   i2cm_bus_model m (.clk_in(clk), .scl_in(scl), .sda_in(sda),
      .scl_lo_out(m_scl), .sda_lo_out(m_sda));
   initial begin
      clk = 0;
      forever #20 clk = !clk;
   end
   task chk(input [15:0] seen, input [15:0] exp);
      begin
         n_compared++;
         if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
         end
      end
   endtask
   task pulse(input [2:0] k);
      begin
         @(negedge clk) pl[k] = 1;
         @(negedge clk) pl = 8'h00;
      end
   endtask
   task wirq;
      integer k;
      begin
         k = 0;
         while (irq !== 1'b1 && k < 3000) begin
            @(negedge clk);
            k++;
         end
         chk(irq, 8'h01);
         pulse(4);
      end
   endtask
   task complete_run;
      begin
         if (err_count == 0 && n_compared > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   initial begin
      {en, general_call_enable, ten, ack_d, pl, wd, err_count, n_compared} = 0;
      rst = 1;
      mode = `I2CM_MODE_MASTER;
      ar = 8'h02;
      repeat (12) @(negedge clk);
      rst = 0;
      en = 1;
      chk({sseen, pseen}, 8'h00);
      pulse(0);
      wirq;
      chk({sseen, sda_oe}, 8'h03);
      wd = 8'hA4;
      pulse(3);
      repeat (10) @(negedge clk);
      wd = 8'h55;
      pulse(3);
      chk({write_collision_flag, busy}, 8'h03);
      wirq;
      chk(m.rx_byte, 8'hA4);
      chk(ackst, 8'h00);
      pulse(5);
      m.ack_en = 0;
      wd = 8'h3C;
      pulse(3);
      wirq;
      chk({m.rx_byte, ackst, write_collision_flag}, 10'h0F2);
      // receive C5h; its first bit is high, so nothing is driven early
      m.tx_byte = 8'hC5;
      m.tx_en = 1;
      pulse(2);
      wirq;
      chk({tbuf, bf, m.ack_seen}, 10'h316);
      m.tx_en = 0;
      pulse(1);
      wirq;
      chk(pseen, 8'h01);
      en = 0;
      @(negedge clk) en = 1;
      chk({sseen, pseen}, 8'h00);
      m.ack_en = 1;
      mode = `I2CM_MODE_SLV10;
      ten = 1;
      ar = 8'hF0;
      // each word: general call enable, byte, expected irq, expected update
      for (i = 0; i < 4; i++) begin
         t = 11'({11'h402, 11'h000, 11'h404, 11'h7C3} >> (33 - 11 * i));
         general_call_enable = t[10];
         m.frame(t[9:2]);
         chk({irq, bf, ua}, {t[1], t[1], t[0]});
         if (t[1]) chk(tbuf, t[9:2]);
         pulse(4);
         pulse(7);
         pulse(6);
         chk(ua, 8'h00);
      end
      complete_run;
   end
   initial begin
      #400_000;
      err_count++;
      complete_run;
   end
endmodule
